// File: pkg/mgmt_irq_pkg.sv
/*
 * Constants for the management interrupt control and enable block: register
 * offset, field positions, reset value and interrupt timing.
 * Assumes a 20 MHz ref_clk standing in for the PCI clock and a simple
 * I/O register port supplied by the surrounding power management decoder.
 */
`default_nettype none

package mgmt_irq_pkg;

	// ========================================
	// Register map
	localparam logic [7:0]  CTRL_OFFSET     = 8'h30;
	localparam logic [31:0] CTRL_RESET      = 32'h0000_0000;
	localparam logic [31:0] CTRL_WRITE_MASK = 32'h0006_687E;

	// ========================================
	// Field positions
	localparam int BIT_GLOBAL_EN   = 0;
	localparam int BIT_END_FLAG    = 1;
	localparam int BIT_FW_TRAP     = 2;
	localparam int BIT_LEGACY_USB  = 3;
	localparam int BIT_SLEEP_TRAP  = 4;
	localparam int BIT_APM_CMD     = 5;
	localparam int BIT_SOFT_TIMER  = 6;
	localparam int BIT_FW_RELEASE  = 7;
	localparam int BIT_MICROCTL    = 11;
	localparam int BIT_WATCHDOG    = 13;
	localparam int BIT_PERIODIC    = 14;
	localparam int BIT_EHCI_LEGACY = 17;
	localparam int BIT_EHCI_VENDOR = 18;

	// ========================================
	// Microcontroller trap ports
	localparam logic [15:0] MICROCTL_PORT_A = 16'h0062;
	localparam logic [15:0] MICROCTL_PORT_B = 16'h0066;

	// ========================================
	// Timing
	localparam int CLK_PERIOD_NS   = 50;
	localparam int PCI_CLK_NS      = 30;
	localparam int DEASSERT_PCI    = 4;
	// Least time rounds up to whole ref_clk cycles.
	localparam int DEASSERT_CYCLES =
		(DEASSERT_PCI * PCI_CLK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int TIMER_W         = 16;

	typedef enum logic [1:0] {
		ARB_FIRST = 2'b00,
		ARB_READY = 2'b01,
		ARB_GAP   = 2'b10,
		ARB_ASSRT = 2'b11
	} arb_state_t;

endpackage

`default_nettype wire

// File: design/soft_irq_timer.sv
/*
 * One-shot software interrupt timer. Counts while enabled and pulses
 * expired once; dropping enable clears the count so a cancelled run
 * produces nothing. Assumes enable and rate from the same clock domain.
 */
`timescale 1ns/1ns
`default_nettype none

module soft_irq_timer (
	input  wire logic                                ref_clk,
	input  wire logic                                resetn,
	input  wire logic                                enable,
	input  wire logic [mgmt_irq_pkg::TIMER_W-1:0]    period,
	output logic                                     expired
);

	logic [mgmt_irq_pkg::TIMER_W-1:0] count_reg;
	logic                             done_reg;

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			count_reg <= '0;
			done_reg  <= 1'b0;
			expired   <= 1'b0;
		end else if (!enable) begin
			count_reg <= '0;
			done_reg  <= 1'b0;
			expired   <= 1'b0;
		end else if (!done_reg && count_reg >= period) begin
			done_reg  <= 1'b1;
			expired   <= 1'b1;
		end else begin
			expired   <= 1'b0;
			if (!done_reg) begin
				count_reg <= count_reg + 1'b1;
			end
		end
	end

endmodule // soft_irq_timer

`default_nettype wire

// File: design/mgmt_irq_arbiter.sv
/*
 * Management interrupt control and enable register with its arbiter.
 * Holds the 32-bit control register, gates each source, runs the
 * software timer and drives the active-low interrupt to the processor.
 * Assumes the power management decoder presents register accesses on
 * reg_* strobes and source events as same-clock pulses or levels.
 */
`timescale 1ns/1ns
`default_nettype none

module mgmt_irq_arbiter (
	input  wire logic        ref_clk,
	input  wire logic        resetn,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	output logic      [31:0] reg_rdata,
	input  wire logic        ehci_vendor_event,
	input  wire logic        ehci_legacy_event,
	input  wire logic        periodic_flag,
	input  wire logic        watchdog_event,
	input  wire logic        nmi_reroute_enable,
	input  wire logic        nmi_event,
	input  wire logic        io_wr,
	input  wire logic        io_rd,
	input  wire logic [15:0] io_addr,
	input  wire logic        apm_command_wr,
	input  wire logic        sleep_request_wr,
	input  wire logic        legacy_usb_event,
	input  wire logic        global_release_wr,
	input  wire logic [15:0] soft_timer_rate,
	input  wire logic        status_pending,
	output logic             io_claim,
	output logic             sleep_allow,
	output logic             acpi_sys_interrupt,
	output logic             soft_timer_flag,
	output logic             mgmt_interrupt_n
);

	// ========================================
	// Control register
	logic [31:0] ctrl_reg;
	logic        ctrl_wr;
	logic        end_clear;
	logic        timer_expired;

	assign ctrl_wr = reg_wr && (reg_addr == mgmt_irq_pkg::CTRL_OFFSET);

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			ctrl_reg <= mgmt_irq_pkg::CTRL_RESET;
		end else begin
			if (ctrl_wr) begin
				ctrl_reg <= reg_wdata & mgmt_irq_pkg::CTRL_WRITE_MASK;
				ctrl_reg[mgmt_irq_pkg::BIT_GLOBAL_EN] <= reg_wdata[mgmt_irq_pkg::BIT_GLOBAL_EN];
			end
			// auto clear end flag, hardware wins over a same-cycle write.
			if (end_clear) begin
				ctrl_reg[mgmt_irq_pkg::BIT_END_FLAG] <= 1'b0;
			end
		end
	end

	// release reads zero, masked out above.
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			reg_rdata <= '0;
		end else if (reg_rd && reg_addr == mgmt_irq_pkg::CTRL_OFFSET) begin
			reg_rdata <= ctrl_reg;
		end else begin
			reg_rdata <= '0;
		end
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			acpi_sys_interrupt <= 1'b0;
		end else begin
			acpi_sys_interrupt <= ctrl_wr && reg_wdata[mgmt_irq_pkg::BIT_FW_RELEASE];
		end
	end

	// ========================================
	// Software timer
	// external rate.
	soft_irq_timer soft_irq_timer_i (
		.ref_clk (ref_clk),
		.resetn  (resetn),
		.enable  (ctrl_reg[mgmt_irq_pkg::BIT_SOFT_TIMER]),
		.period  (soft_timer_rate),
		.expired (timer_expired)
	);

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			soft_timer_flag <= 1'b0;
		end else if (timer_expired) begin
			soft_timer_flag <= 1'b1;
		end else if (!ctrl_reg[mgmt_irq_pkg::BIT_SOFT_TIMER]) begin
			soft_timer_flag <= 1'b0;
		end
	end

	// ========================================
	// Traps
	logic micro_hit;
	assign micro_hit = (io_wr || io_rd) &&
		(io_addr == mgmt_irq_pkg::MICROCTL_PORT_A || io_addr == mgmt_irq_pkg::MICROCTL_PORT_B);

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			io_claim <= 1'b0;
		end else begin
			io_claim <= micro_hit && ctrl_reg[mgmt_irq_pkg::BIT_MICROCTL];
		end
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			sleep_allow <= 1'b0;
		end else begin
			sleep_allow <= sleep_request_wr && !ctrl_reg[mgmt_irq_pkg::BIT_SLEEP_TRAP];
		end
	end

	// ========================================
	// Request forming
	logic src_any;
	logic pending_reg;

	always_comb begin
		src_any = 1'b0;
		src_any |= ehci_vendor_event && ctrl_reg[mgmt_irq_pkg::BIT_EHCI_VENDOR];
		src_any |= ehci_legacy_event && ctrl_reg[mgmt_irq_pkg::BIT_EHCI_LEGACY];
		src_any |= periodic_flag && ctrl_reg[mgmt_irq_pkg::BIT_PERIODIC];
		src_any |= watchdog_event && ctrl_reg[mgmt_irq_pkg::BIT_WATCHDOG];
		src_any |= nmi_event && nmi_reroute_enable;
		src_any |= micro_hit && ctrl_reg[mgmt_irq_pkg::BIT_MICROCTL];
		src_any |= timer_expired;
		src_any |= apm_command_wr && ctrl_reg[mgmt_irq_pkg::BIT_APM_CMD];
		src_any |= sleep_request_wr && ctrl_reg[mgmt_irq_pkg::BIT_SLEEP_TRAP];
		src_any |= legacy_usb_event && ctrl_reg[mgmt_irq_pkg::BIT_LEGACY_USB];
		src_any |= global_release_wr && ctrl_reg[mgmt_irq_pkg::BIT_FW_TRAP];
		src_any &= ctrl_reg[mgmt_irq_pkg::BIT_GLOBAL_EN];
	end

	// Pulse sources are latched so none is lost while the arbiter waits.
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			pending_reg <= 1'b0;
		end else if (src_any) begin
			pending_reg <= 1'b1;
		end else if (end_clear || !ctrl_reg[mgmt_irq_pkg::BIT_GLOBAL_EN]) begin
			pending_reg <= 1'b0;
		end
	end

	// ========================================
	// Arbiter
	mgmt_irq_pkg::arb_state_t state_reg;
	logic [2:0]               gap_reg;
	logic                     want;

	assign want      = (pending_reg || status_pending) && ctrl_reg[mgmt_irq_pkg::BIT_GLOBAL_EN];
	assign end_clear = (state_reg == mgmt_irq_pkg::ARB_GAP) &&
		(gap_reg == 3'(mgmt_irq_pkg::DEASSERT_CYCLES - 1)) &&
		ctrl_reg[mgmt_irq_pkg::BIT_GLOBAL_EN];

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			state_reg        <= mgmt_irq_pkg::ARB_FIRST;
			gap_reg          <= '0;
			mgmt_interrupt_n <= 1'b1;
		end else begin
			case (state_reg)
				mgmt_irq_pkg::ARB_FIRST, mgmt_irq_pkg::ARB_READY: begin
					mgmt_interrupt_n <= 1'b1;
					gap_reg          <= '0;
					if (want && (state_reg == mgmt_irq_pkg::ARB_FIRST ||
						ctrl_reg[mgmt_irq_pkg::BIT_END_FLAG])) begin
						state_reg <= mgmt_irq_pkg::ARB_GAP;
					end
				end
				mgmt_irq_pkg::ARB_GAP: begin
					mgmt_interrupt_n <= 1'b1;
					// restart gap while disabled, so a full gap runs again after re-enable.
					if (ctrl_reg[mgmt_irq_pkg::BIT_GLOBAL_EN]) begin
						gap_reg <= gap_reg + 3'd1;
					end else begin
						gap_reg <= '0;
					end
					if (end_clear) begin
						mgmt_interrupt_n <= 1'b0;
						state_reg        <= mgmt_irq_pkg::ARB_ASSRT;
					end
				end
				mgmt_irq_pkg::ARB_ASSRT: begin
					// handler sets end flag to rearm.
					if (ctrl_reg[mgmt_irq_pkg::BIT_END_FLAG]) begin
						mgmt_interrupt_n <= 1'b1;
						state_reg        <= mgmt_irq_pkg::ARB_READY;
					end
				end
				default: begin
					state_reg        <= mgmt_irq_pkg::ARB_READY;
					mgmt_interrupt_n <= 1'b1;
				end
			endcase
		end
	end

	// ========================================
	// Checks
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!resetn);

	// The output stays high for the whole gap once it starts.
	sequence s_gap;
		mgmt_interrupt_n [*3];
	endsequence

	property p_gap_hold;
		$rose(state_reg == mgmt_irq_pkg::ARB_GAP) |-> s_gap;
	endproperty
	a_gap_hold: assert property (p_gap_hold) else $error("output fell inside gap");

	property p_gap;
		$fell(mgmt_interrupt_n) |-> $past(mgmt_interrupt_n, 1) && $past(mgmt_interrupt_n, 2)
			&& $past(mgmt_interrupt_n, 3);
	endproperty
	a_gap: assert property (p_gap) else $error("interrupt asserted without high gap");

	property p_end_clear;
		$fell(mgmt_interrupt_n) |-> !ctrl_reg[mgmt_irq_pkg::BIT_END_FLAG];
	endproperty
	a_end_clear: assert property (p_end_clear) else $error("end flag not cleared");

	property p_global;
		!ctrl_reg[mgmt_irq_pkg::BIT_GLOBAL_EN] |=> !$fell(mgmt_interrupt_n);
	endproperty
	a_global: assert property (p_global) else $error("interrupt with global off");

	property p_release_read;
		reg_rd ##1 1'b1 |-> !reg_rdata[mgmt_irq_pkg::BIT_FW_RELEASE];
	endproperty
	a_release_read: assert property (p_release_read) else $error("release bit read one");

	property p_acpi;
		ctrl_wr && reg_wdata[mgmt_irq_pkg::BIT_FW_RELEASE] |=> acpi_sys_interrupt;
	endproperty
	a_acpi: assert property (p_acpi) else $error("no ACPI pulse on release");

	property p_timer_cancel;
		!ctrl_reg[mgmt_irq_pkg::BIT_SOFT_TIMER] |=> !timer_expired;
	endproperty
	a_timer_cancel: assert property (p_timer_cancel) else $error("cancelled timer fired");

	property p_sleep_trap;
		sleep_request_wr && ctrl_reg[mgmt_irq_pkg::BIT_SLEEP_TRAP] |=> !sleep_allow;
	endproperty
	a_sleep_trap: assert property (p_sleep_trap) else $error("trapped sleep allowed");

	property p_claim;
		micro_hit && ctrl_reg[mgmt_irq_pkg::BIT_MICROCTL] |=> io_claim;
	endproperty
	a_claim: assert property (p_claim) else $error("trap not claimed");

	property p_rearm;
		state_reg == mgmt_irq_pkg::ARB_ASSRT && !ctrl_reg[mgmt_irq_pkg::BIT_END_FLAG]
			|=> !mgmt_interrupt_n;
	endproperty
	a_rearm: assert property (p_rearm) else $error("released without end flag");

	property p_first;
		state_reg == mgmt_irq_pkg::ARB_FIRST && want
			|=> state_reg == mgmt_irq_pkg::ARB_GAP;
	endproperty
	a_first: assert property (p_first) else $error("first request refused");

	property p_ready_flag;
		state_reg == mgmt_irq_pkg::ARB_READY && !ctrl_reg[mgmt_irq_pkg::BIT_END_FLAG]
			|=> state_reg == mgmt_irq_pkg::ARB_READY;
	endproperty
	a_ready_flag: assert property (p_ready_flag) else $error("left ready without flag");

	property p_reserved;
		(ctrl_reg & ~(mgmt_irq_pkg::CTRL_WRITE_MASK | 32'h0000_0001)) == 32'h0000_0000;
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved bit held one");

	property p_release_store;
		ctrl_wr |=> !ctrl_reg[mgmt_irq_pkg::BIT_FW_RELEASE];
	endproperty
	a_release_store: assert property (p_release_store) else $error("release stored");

	property p_expire_flag;
		timer_expired |=> soft_timer_flag;
	endproperty
	a_expire_flag: assert property (p_expire_flag) else $error("expiry left flag clear");

	property p_blocked;
		!ctrl_reg[mgmt_irq_pkg::BIT_GLOBAL_EN] |=> !pending_reg;
	endproperty
	a_blocked: assert property (p_blocked) else $error("request kept with global off");

	property p_src_vendor;
		ehci_vendor_event && ctrl_reg[mgmt_irq_pkg::BIT_EHCI_VENDOR]
			&& ctrl_reg[mgmt_irq_pkg::BIT_GLOBAL_EN] |=> pending_reg;
	endproperty
	a_src_vendor: assert property (p_src_vendor) else $error("vendor source lost");

	property p_src_legacy;
		ehci_legacy_event && ctrl_reg[mgmt_irq_pkg::BIT_EHCI_LEGACY]
			&& ctrl_reg[mgmt_irq_pkg::BIT_GLOBAL_EN] |=> pending_reg;
	endproperty
	a_src_legacy: assert property (p_src_legacy) else $error("legacy source lost");

	property p_src_periodic;
		periodic_flag && ctrl_reg[mgmt_irq_pkg::BIT_PERIODIC]
			&& ctrl_reg[mgmt_irq_pkg::BIT_GLOBAL_EN] |=> pending_reg;
	endproperty
	a_src_periodic: assert property (p_src_periodic) else $error("periodic source lost");

	property p_src_nmi;
		nmi_event && nmi_reroute_enable
			&& ctrl_reg[mgmt_irq_pkg::BIT_GLOBAL_EN] |=> pending_reg;
	endproperty
	a_src_nmi: assert property (p_src_nmi) else $error("rerouted NMI lost");

	property p_src_apm;
		apm_command_wr && ctrl_reg[mgmt_irq_pkg::BIT_APM_CMD]
			&& ctrl_reg[mgmt_irq_pkg::BIT_GLOBAL_EN] |=> pending_reg;
	endproperty
	a_src_apm: assert property (p_src_apm) else $error("APM command lost");

endmodule // mgmt_irq_arbiter

`default_nettype wire

// File: verification/mgmt_cpu_model.sv
/*
 * Processor-side model of the management interrupt receiver.
 * Assumes the interrupt line is registered on ref_clk and that the bench
 * performs the end-of-handler register write when handler_req is high.
 */
`timescale 1ns/1ns
`default_nettype none

module mgmt_cpu_model #(
	parameter int SVC_CYCLES = 6
) (
	input  wire logic ref_clk,
	input  wire logic resetn,
	input  wire logic mgmt_interrupt_n,
	output logic      status_pending,
	output logic      handler_req
);
	// ========================================
	// Handler
	logic irq_n_prev;
	int   svc_cnt;

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			irq_n_prev     <= 1'b1;
			svc_cnt        <= 0;
			status_pending <= 1'b0;
			handler_req    <= 1'b0;
		end else begin
			irq_n_prev <= mgmt_interrupt_n;
			if (irq_n_prev && !mgmt_interrupt_n) begin
				status_pending <= 1'b1;
				svc_cnt        <= SVC_CYCLES;
			end else if (svc_cnt > 1) begin
				svc_cnt <= svc_cnt - 1;
			end else if (svc_cnt == 1) begin
				svc_cnt        <= 0;
				status_pending <= 1'b0;
				handler_req    <= 1'b1;
			end
			if (mgmt_interrupt_n)
				handler_req <= 1'b0;
		end
	end
endmodule // mgmt_cpu_model

`default_nettype wire

// File: verification/mgmt_irq_arbiter_test.sv
/*
 * Self-checking bench for the management interrupt arbiter.
 * Assumes the processor model answers each interrupt by raising handler_req.
 */
`timescale 1ns/1ns
`default_nettype none

module mgmt_irq_arbiter_test;
	// ========================================
	// Signals
	localparam logic [2:0] EV_IRQ = 3'h1, EV_ACPI = 3'h2, EV_CLAIM = 3'h3;
	localparam logic [2:0] EV_SLEEP = 3'h4, EV_FLAG = 3'h5;
	localparam logic [31:0] EN_TAB [10] = '{
		32'h0004_0000, 32'h0002_0000, 32'h0000_4000,
		32'h0000_2000, 32'h0000_0000, 32'h0000_0008,
		32'h0000_0020, 32'h0000_0004, 32'h0000_0010, 32'h0000_0800
	};
	logic        ref_clk, resetn, reg_wr, reg_rd, io_wr, io_rd, nmi_reroute_enable;
	logic        ehci_vendor_event, ehci_legacy_event, periodic_flag, watchdog_event;
	logic        nmi_event, apm_command_wr, sleep_request_wr, legacy_usb_event;
	logic        global_release_wr, status_pending, io_claim, sleep_allow, handler_req;
	logic        acpi_sys_interrupt, soft_timer_flag, mgmt_interrupt_n;
	logic [7:0]  reg_addr;
	logic [31:0] reg_wdata, reg_rdata;
	logic [15:0] io_addr, soft_timer_rate;
	logic [15:0] seed = 16'h001A;
	logic [2:0]  ev_q[$];
	logic [31:0] rd_q[$];
	logic        rd_d, irq_d, flag_d;
	int          hi_run, n_errors, check_count, n_case;

	mgmt_irq_arbiter mgmt_irq_arbiter_i (.ref_clk(ref_clk), .resetn(resetn), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.ehci_vendor_event(ehci_vendor_event), .ehci_legacy_event(ehci_legacy_event),
		.periodic_flag(periodic_flag), .watchdog_event(watchdog_event),
		.nmi_reroute_enable(nmi_reroute_enable), .nmi_event(nmi_event), .io_wr(io_wr),
		.io_rd(io_rd), .io_addr(io_addr), .apm_command_wr(apm_command_wr),
		.sleep_request_wr(sleep_request_wr), .legacy_usb_event(legacy_usb_event),
		.global_release_wr(global_release_wr), .soft_timer_rate(soft_timer_rate),
		.status_pending(status_pending), .io_claim(io_claim), .sleep_allow(sleep_allow),
		.acpi_sys_interrupt(acpi_sys_interrupt), .soft_timer_flag(soft_timer_flag),
		.mgmt_interrupt_n(mgmt_interrupt_n));

	mgmt_cpu_model #(.SVC_CYCLES(6)) mgmt_cpu_model_i (.ref_clk(ref_clk), .resetn(resetn),
		.mgmt_interrupt_n(mgmt_interrupt_n), .status_pending(status_pending),
		.handler_req(handler_req));

	always #25 ref_clk = ~ref_clk;

	// ========================================
	// Checking
	function logic [15:0] rnd();
		seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
		return seed;
	endfunction

	task automatic fail(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_errors++;
		$display("wrong value %s expected %h seen %h", what, exp, got);
	endtask

	task automatic chk_ev(input logic [2:0] exp, input logic [2:0] got);
		check_count++;
		if (got !== exp) fail("event", {29'h0, exp}, {29'h0, got});
	endtask

	task automatic chk_rd(input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp) fail("read data", exp, got);
	endtask

	task automatic chk_lvl(input string what, input logic exp, input logic got);
		check_count++;
		if (got !== exp) fail(what, {31'h0, exp}, {31'h0, got});
	endtask

	// Any event seen with nothing expected is a mismatch.
	task automatic see(input logic [2:0] code);
		if (ev_q.size() == 0) fail("event", 32'h0, {29'h0, code});
		else chk_ev(ev_q.pop_front(), code);
	endtask

	always @(posedge ref_clk) begin
		if (resetn) begin
			if (rd_d) chk_rd(rd_q.pop_front(), reg_rdata);
			if (irq_d && !mgmt_interrupt_n) begin
				chk_lvl("gap", 1'b1, hi_run >= mgmt_irq_pkg::DEASSERT_CYCLES);
				see(EV_IRQ);
			end
			if (acpi_sys_interrupt) see(EV_ACPI);
			if (io_claim) see(EV_CLAIM);
			if (sleep_allow) see(EV_SLEEP);
			if (soft_timer_flag && !flag_d) see(EV_FLAG);
		end
		rd_d = reg_rd;
		irq_d = mgmt_interrupt_n;
		flag_d = soft_timer_flag;
		hi_run = mgmt_interrupt_n ? hi_run + 1 : 0;
	end

	// ========================================
	// Driving
	task automatic reg_write(input logic [31:0] d);
		@(posedge ref_clk);
		reg_wr    <= 1'b1;
		reg_addr  <= mgmt_irq_pkg::CTRL_OFFSET;
		reg_wdata <= d;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask

	task automatic reg_read(input logic [7:0] a, input logic [31:0] exp);
		rd_q.push_back(exp);
		@(posedge ref_clk);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		repeat (2) @(posedge ref_clk);
	endtask

	task automatic pulse(input int s);
		logic [15:0] r;
		r = rnd();
		@(posedge ref_clk);
		case (s)
			1: ehci_vendor_event <= 1'b1;
			2: ehci_legacy_event <= 1'b1;
			3: periodic_flag <= 1'b1;
			4: watchdog_event <= 1'b1;
			5: nmi_event <= 1'b1;
			6: legacy_usb_event <= 1'b1;
			7: apm_command_wr <= 1'b1;
			8: global_release_wr <= 1'b1;
			9: sleep_request_wr <= 1'b1;
			10: begin
				io_addr <= r[1] ? mgmt_irq_pkg::MICROCTL_PORT_A : mgmt_irq_pkg::MICROCTL_PORT_B;
				io_wr   <= r[0];
				io_rd   <= !r[0];
			end
			11: begin
				io_addr <= r | 16'h0100;
				io_wr   <= 1'b1;
			end
			default: ;
		endcase
		@(posedge ref_clk);
		{ehci_vendor_event, ehci_legacy_event, periodic_flag, watchdog_event, nmi_event,
			legacy_usb_event, apm_command_wr, global_release_wr, sleep_request_wr, io_wr,
			io_rd} <= '0;
	endtask

	task automatic run_case(input logic [31:0] ctrl, input int s, input logic irq,
		input logic [2:0] side);
		int n;
		reg_write(ctrl);
		if (side != 3'h0) ev_q.push_back(side);
		if (irq) ev_q.push_back(EV_IRQ);
		pulse(s);
		for (n = 0; n < 100 && ev_q.size() != 0; n++) @(posedge ref_clk);
		if (ev_q.size() != 0) begin
			fail("missing event", 32'h0, {29'h0, ev_q[0]});
			ev_q.delete();
		end
		repeat (50) @(posedge ref_clk);
		if (irq) begin
			for (n = 0; n < 50 && !handler_req; n++) @(posedge ref_clk);
			@(negedge ref_clk);
			chk_lvl("held low", 1'b0, mgmt_interrupt_n);
			reg_write(ctrl | 32'h0000_0002);
			repeat (2) @(negedge ref_clk);
			chk_lvl("released", 1'b1, mgmt_interrupt_n);
		end
		n_case++;
		$display("case %0d done", n_case);
	endtask

	task automatic test_done();
		$display("checks %0d mismatches %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// ========================================
	// Sequence
	initial begin
		logic [31:0] d;
		ref_clk = 1'b0;
		resetn = 1'b0;
		{reg_wr, reg_rd, io_wr, io_rd, nmi_reroute_enable, ehci_vendor_event, ehci_legacy_event,
			periodic_flag, watchdog_event, nmi_event, apm_command_wr, sleep_request_wr,
			legacy_usb_event, global_release_wr} = '0;
		{reg_addr, reg_wdata, io_addr} = '0;
		soft_timer_rate = 16'h0008 | (rnd() & 16'h001F);
		repeat (12) @(posedge ref_clk);
		resetn <= 1'b1;
		reg_read(mgmt_irq_pkg::CTRL_OFFSET, mgmt_irq_pkg::CTRL_RESET);
		run_case(32'h0000_0022, 7, 1'b0, 3'h0);
		run_case(32'h0000_0021, 7, 1'b1, 3'h0);
		for (int s = 1; s <= 10; s++) begin
			nmi_reroute_enable <= 1'b0;
			run_case(32'h0000_0003, s, 1'b0, s == 9 ? EV_SLEEP : 3'h0);
			nmi_reroute_enable <= 1'b1;
			run_case(32'h0000_0003 | EN_TAB[s-1], s, 1'b1, s == 10 ? EV_CLAIM : 3'h0);
		end
		run_case(32'h0000_0803, 11, 1'b0, 3'h0);
		run_case(32'h0000_0043, 0, 1'b1, EV_FLAG);
		chk_lvl("timer flag", 1'b1, soft_timer_flag);
		run_case(32'h0000_0003, 0, 1'b0, 3'h0);
		chk_lvl("timer flag", 1'b0, soft_timer_flag);
		reg_write(32'h0000_0043);
		repeat (2) @(posedge ref_clk);
		run_case(32'h0000_0003, 0, 1'b0, 3'h0);
		chk_lvl("timer flag", 1'b0, soft_timer_flag);
		reg_write(32'h0000_0021);
		pulse(7);
		repeat (20) @(posedge ref_clk);
		run_case(32'h0000_0023, 0, 1'b1, 3'h0);
		run_case(32'h0000_0083, 0, 1'b0, EV_ACPI);
		reg_read(mgmt_irq_pkg::CTRL_OFFSET, 32'h0000_0003);
		d = {rnd(), rnd()} & 32'hFFFF_FF3F;
		reg_write(d);
		d = d & (mgmt_irq_pkg::CTRL_WRITE_MASK | 32'h0000_0001);
		reg_read(mgmt_irq_pkg::CTRL_OFFSET, d);
		reg_read(8'h34, 32'h0000_0000);
		resetn <= 1'b0;
		repeat (3) @(posedge ref_clk);
		resetn <= 1'b1;
		reg_read(mgmt_irq_pkg::CTRL_OFFSET, mgmt_irq_pkg::CTRL_RESET);
		run_case(32'h0000_0021, 7, 1'b1, 3'h0);
		test_done();
	end

	initial begin
		repeat (20000) @(posedge ref_clk);
		n_errors++;
		test_done();
	end
endmodule // mgmt_irq_arbiter_test

`default_nettype wire
